// File: design/tsga_pkg.sv
// Register map, field layout and link constants of the TDM slot and gain alignment block
package tsga_pkg;
  // Register indices; Avalon word address equals the index
  localparam int unsigned ADDR_W        = 5;
  localparam logic [4:0]  REG_GAIN_SLOT = 5'h14;
  localparam logic [4:0]  REG_PIN_CFG   = 5'h15;
  localparam logic [4:0]  REG_AUDIO     = 5'h16;
  localparam logic [4:0]  REG_ALIGN     = 5'h17;
  localparam logic [4:0]  REG_MEMBER    = 5'h18;
  localparam logic [4:0]  REG_LINK_GPIO = 5'h1e;
  // Reset values
  localparam logic [7:0]  RST_GAIN_SLOT = 8'h0a;
  localparam logic [7:0]  RST_PIN_CFG   = 8'h00;
  localparam logic [7:0]  RST_AUDIO     = 8'h12;
  localparam logic [7:0]  RST_ALIGN     = 8'h0c;
  localparam logic [7:0]  RST_MEMBER    = 8'h00;
  // Writable bits; all others read zero, except bit 1 of the link GPIO register, which reads the general purpose input
  localparam logic [7:0]  MASK_GAIN     = 8'h7f;
  localparam logic [7:0]  MASK_PIN      = 8'h1c;
  localparam logic [7:0]  MASK_FULL     = 8'hff;
  localparam logic [7:0]  MASK_GPIO     = 8'h01;
  // Field positions
  localparam int unsigned TX_EN_BIT     = 6;
  localparam int unsigned SLEN_BIT      = 7;
  localparam int unsigned SLOT_LSB      = 0;
  localparam int unsigned SLOT_W        = 6;
  localparam int unsigned PINFN_LSB     = 2;
  localparam int unsigned PINFN_W       = 3;
  localparam int unsigned BO_EN_BIT     = 7;
  localparam int unsigned START_LSB     = 1;
  localparam int unsigned LIM_EN_BIT    = 0;
  localparam int unsigned GPO_BIT       = 0;
  localparam int unsigned GPI_BIT       = 1;
  // Alignment group
  localparam int unsigned N_MEMBERS     = 8;
  localparam int unsigned MEMBER_STEP   = 3;
  // TDM frame: 64 slots of 32 bit clocks
  localparam int unsigned SLOT_BITS_W   = 5;
  localparam int unsigned CNT_W         = SLOT_W + SLOT_BITS_W;
  localparam int unsigned AUDIO_SHORT   = 16;
  localparam int unsigned AUDIO_LONG    = 24;
  // Pin function codes; others reserved, treated as buffers off
  typedef enum logic [2:0] {
    TSGA_PF_ALIGN = 3'h0,
    TSGA_PF_OFF   = 3'h2,
    TSGA_PF_GPI   = 3'h3,
    TSGA_PF_GPO   = 3'h4
  } tsga_pin_fn_t;
endpackage

// File: design/tsga_top.sv
// TDM slot placement, chip link pin and gain alignment group with Avalon-MM registers
//
// What this block does
// - Gain-reduction word goes out in its slot only while its transmit enable is 1.
// - Bits 5-0 of the gain register pick the gain-reduction slot 0..63, reset 0xA.
// - Pin function 0 makes the chip link pin carry gain alignment, 2 turns its buffers off.
// - Pin function 3 makes the chip link pin a general purpose input, 4 a general purpose output.
// - Audio word length bit sends 16 bits when 0 and 24 bits when 1.
// - Audio goes out on TDM only while its transmit enable is 1.
// - Bits 5-0 of the audio register pick the audio slot, reset 0x12.
// - Bit 7 of the alignment control enables brownout gain alignment with peers.
// - Bits 6-1 of the alignment control give the group start slot, reset 6.
// - Bit 0 of the alignment control enables limiter gain alignment with the group.
// - Member bit n of 1..7 adds slot start plus 3n to the group.
// - Member bit 0 adds the start slot itself to the group.
`timescale 1ns/1ps
`default_nettype none

module tsga_fifo #(
  parameter int unsigned W     = 24,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PTR_W-1:0]        wp;
    logic [PTR_W-1:0]        rp;
    logic [CNT_W-1:0]        cnt;
    logic                    room;
    logic                    avail;
  } tsga_fifo_st_t;

  tsga_fifo_st_t st_q;
  tsga_fifo_st_t st_d;
  logic          push;
  logic          pop;

  assign push      = in_valid && st_q.room && ce;
  assign pop       = out_ready && st_q.avail && ce;
  assign in_ready  = st_q.room;
  assign out_valid = st_q.avail;
  assign out_data  = st_q.mem[st_q.rp];

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = in_data;
      st_d.wp = (st_q.wp == LAST) ? '0 : st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = (st_q.rp == LAST) ? '0 : st_q.rp + 1'b1;
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
    st_d.room  = (st_d.cnt != FULL);
    st_d.avail = (st_d.cnt != '0);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q       <= '0;
      st_q.room  <= 1'b1;
    end else if (ce) begin
      st_q <= st_d;
    end
  end
endmodule

module tsga_top #(
  parameter int unsigned AUDIO_W    = 24,
  parameter int unsigned GAIN_W     = 8,
  parameter int unsigned FIFO_DEPTH = 16
) (
  // Clock, reset, enable
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  // Avalon-MM slave
  input  wire logic [tsga_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic [31:0]                       avs_readdata,
  output logic                              avs_waitrequest,
  // TDM pins
  input  wire logic                         tdm_bclk,
  input  wire logic                         tdm_fsync,
  output logic                              tdm_dout,
  output logic                              tdm_dout_oe_n,
  // Chip link pin
  input  wire logic                         chip_link_pin_i,
  output logic                              chip_link_pin_o,
  output logic                              chip_link_pin_oe_n,
  // Audio sample stream
  input  wire logic [AUDIO_W-1:0]           aud_data,
  input  wire logic                         aud_valid,
  output logic                              aud_ready,
  // Limiter and brownout gains
  input  wire logic [GAIN_W-1:0]            gain_reduction,
  input  wire logic [GAIN_W-1:0]            brownout_gain,
  output logic [GAIN_W-1:0]                 limiter_gain_aligned,
  output logic [GAIN_W-1:0]                 brownout_gain_aligned
);
  import tsga_pkg::*;

  typedef struct packed {
    logic [7:0]             gain_cfg;
    logic [7:0]             pin_cfg;
    logic [7:0]             audio_cfg;
    logic [7:0]             align_cfg;
    logic [7:0]             member_sel;
    logic                   gpo;
    logic                   gpi;
    logic                   waitreq;
    logic [7:0]             rdata;
    logic [1:0]             bclk_s;
    logic [1:0]             fsync_s;
    logic [1:0]             link_s;
    logic                   bclk_prev;
    logic                   fsync_prev;
    logic [CNT_W-1:0]       cnt;
    logic [AUDIO_W-1:0]     aud_hold;
    logic                   aud_ok;
    logic [GAIN_W-1:0]      gain_hold;
    logic [GAIN_W-1:0]      peer_sh;
    logic [GAIN_W-1:0]      frame_max;
    logic [GAIN_W-1:0]      peer_max;
    logic                   dout;
    logic                   dout_oe_n;
    logic                   link_o;
    logic                   link_oe_n;
    logic [GAIN_W-1:0]      lim_al;
    logic [GAIN_W-1:0]      bo_al;
  } tsga_st_t;

  tsga_st_t              st_q;
  tsga_st_t              st_d;
  logic [AUDIO_W-1:0]    fifo_data;
  logic                  fifo_valid;
  logic                  fifo_pop;
  logic                  rise;
  logic                  fall;
  logic                  fstart;
  logic [SLOT_W-1:0]     slot;
  logic [SLOT_BITS_W-1:0] bitpos;
  logic [SLOT_W-1:0]     start;
  logic [N_MEMBERS-1:0]  hit;
  logic                  in_group;
  logic [2:0]            pin_fn;
  logic                  align_mode;
  logic                  gain_en;
  logic                  audio_en;
  logic                  drv_gain;
  logic                  drv_aud;
  logic                  req;
  logic [7:0]            rd_mux;
  logic [GAIN_W-1:0]     peer_word;
  int unsigned           aud_len;

  assign rise       = st_q.bclk_s[1] && !st_q.bclk_prev;
  assign fall       = !st_q.bclk_s[1] && st_q.bclk_prev;
  assign fstart     = rise && st_q.fsync_s[1] && !st_q.fsync_prev;
  assign slot       = st_q.cnt[CNT_W-1:SLOT_BITS_W];
  assign bitpos     = st_q.cnt[SLOT_BITS_W-1:0];
  assign start      = st_q.align_cfg[START_LSB +: SLOT_W];
  assign pin_fn     = st_q.pin_cfg[PINFN_LSB +: PINFN_W];
  assign align_mode = (pin_fn == TSGA_PF_ALIGN);
  assign gain_en    = st_q.gain_cfg[TX_EN_BIT];
  assign audio_en   = st_q.audio_cfg[TX_EN_BIT];
  assign aud_len    = st_q.audio_cfg[SLEN_BIT] ? AUDIO_LONG : AUDIO_SHORT;
  assign drv_aud    = audio_en && st_q.aud_ok && (slot == st_q.audio_cfg[SLOT_LSB +: SLOT_W]);
  assign drv_gain   = gain_en && (slot == st_q.gain_cfg[SLOT_LSB +: SLOT_W]);
  assign fifo_pop   = fstart && audio_en && ce;
  assign req        = avs_read || avs_write;
  assign peer_word  = {st_q.peer_sh[GAIN_W-2:0], st_q.link_s[1]};

  // Group member slots; offsets wrap modulo 64
  genvar n;
  generate
    for (n = 0; n < N_MEMBERS; n++) begin : g_member
      localparam logic [SLOT_W-1:0] OFS = SLOT_W'(MEMBER_STEP * n);
      assign hit[n] = st_q.member_sel[n] && (slot == SLOT_W'(start + OFS));
    end
  endgenerate
  assign in_group = |hit;

  tsga_fifo #(
    .W     (AUDIO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   (aud_data),
    .in_valid  (aud_valid),
    .in_ready  (aud_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  always_comb begin
    case (avs_address)
      REG_GAIN_SLOT: rd_mux = st_q.gain_cfg;
      REG_PIN_CFG:   rd_mux = st_q.pin_cfg;
      REG_AUDIO:     rd_mux = st_q.audio_cfg;
      REG_ALIGN:     rd_mux = st_q.align_cfg;
      REG_MEMBER:    rd_mux = st_q.member_sel;
      REG_LINK_GPIO: rd_mux = 8'({st_q.gpi, st_q.gpo});
      default:       rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    st_d = st_q;
    // Bus: one wait cycle, then the access takes effect
    st_d.waitreq = !(req && st_q.waitreq);
    if (req && st_q.waitreq) begin
      st_d.rdata = avs_read ? rd_mux : 8'h00;
    end
    if (avs_write && !st_q.waitreq && avs_byteenable[0]) begin
      case (avs_address)
        REG_GAIN_SLOT: st_d.gain_cfg   = avs_writedata[7:0] & MASK_GAIN;
        REG_PIN_CFG:   st_d.pin_cfg    = avs_writedata[7:0] & MASK_PIN;
        REG_AUDIO:     st_d.audio_cfg  = avs_writedata[7:0] & MASK_FULL;
        REG_ALIGN:     st_d.align_cfg  = avs_writedata[7:0] & MASK_FULL;
        REG_MEMBER:    st_d.member_sel = avs_writedata[7:0] & MASK_FULL;
        REG_LINK_GPIO: st_d.gpo        = avs_writedata[GPO_BIT];
        default:       st_d.gpo        = st_q.gpo;
      endcase
    end
    // Pin synchronisers
    st_d.bclk_s    = {st_q.bclk_s[0], tdm_bclk};
    st_d.fsync_s   = {st_q.fsync_s[0], tdm_fsync};
    st_d.link_s    = {st_q.link_s[0], chip_link_pin_i};
    st_d.bclk_prev = st_q.bclk_s[1];
    if (pin_fn == TSGA_PF_GPI) begin
      st_d.gpi = st_q.link_s[1];
    end
    // Frame position and sampling on bit clock rise
    if (rise) begin
      st_d.fsync_prev = st_q.fsync_s[1];
      if (fstart) begin
        st_d.cnt       = '0;
        st_d.peer_max  = st_q.frame_max;
        st_d.frame_max = '0;
        st_d.gain_hold = gain_reduction;
        st_d.aud_hold  = fifo_data;
        st_d.aud_ok    = audio_en && fifo_valid;
      end else begin
        st_d.cnt = st_q.cnt + 1'b1;
        if (align_mode && in_group && (bitpos < SLOT_BITS_W'(GAIN_W))) begin
          st_d.peer_sh = peer_word;
          if ((bitpos == SLOT_BITS_W'(GAIN_W - 1)) && (peer_word > st_q.frame_max)) begin
            st_d.frame_max = peer_word;
          end
        end
      end
    end
    // Drive on bit clock fall; audio wins a slot clash
    if (fall) begin
      st_d.dout      = 1'b0;
      st_d.dout_oe_n = !(drv_aud || drv_gain);
      if (drv_aud) begin
        if (int'(bitpos) < aud_len) begin
          st_d.dout = st_q.aud_hold[AUDIO_W - 1 - int'(bitpos)];
        end
      end else if (drv_gain && (bitpos < SLOT_BITS_W'(GAIN_W))) begin
        st_d.dout = st_q.gain_hold[GAIN_W - 1 - int'(bitpos)];
      end
    end
    // Chip link pin function
    case (pin_fn)
      TSGA_PF_ALIGN: begin
        if (fall) begin
          st_d.link_oe_n = !drv_gain;
          st_d.link_o    = drv_gain && (bitpos < SLOT_BITS_W'(GAIN_W)) &&
                           st_q.gain_hold[GAIN_W - 1 - int'(bitpos)];
        end
      end
      TSGA_PF_GPO: begin
        st_d.link_oe_n = 1'b0;
        st_d.link_o    = st_q.gpo;
      end
      default: begin
        st_d.link_oe_n = 1'b1;
        st_d.link_o    = 1'b0;
      end
    endcase
    if (!align_mode) begin
      st_d.peer_max  = '0;
      st_d.frame_max = '0;
    end
    // Aligned gains: the larger attenuation of own and group
    st_d.lim_al = gain_reduction;
    st_d.bo_al  = brownout_gain;
    if (st_q.align_cfg[LIM_EN_BIT] && st_q.peer_max > gain_reduction) begin
      st_d.lim_al = st_q.peer_max;
    end
    if (st_q.align_cfg[BO_EN_BIT] && st_q.peer_max > brownout_gain) begin
      st_d.bo_al = st_q.peer_max;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q            <= '0;
      st_q.gain_cfg   <= RST_GAIN_SLOT;
      st_q.pin_cfg    <= RST_PIN_CFG;
      st_q.audio_cfg  <= RST_AUDIO;
      st_q.align_cfg  <= RST_ALIGN;
      st_q.member_sel <= RST_MEMBER;
      st_q.waitreq    <= 1'b1;
      st_q.dout_oe_n  <= 1'b1;
      st_q.link_oe_n  <= 1'b1;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign avs_readdata          = {24'h000000, st_q.rdata};
  assign avs_waitrequest       = st_q.waitreq;
  assign tdm_dout              = st_q.dout;
  assign tdm_dout_oe_n         = st_q.dout_oe_n;
  assign chip_link_pin_o       = st_q.link_o;
  assign chip_link_pin_oe_n    = st_q.link_oe_n;
  assign limiter_gain_aligned  = st_q.lim_al;
  assign brownout_gain_aligned = st_q.bo_al;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_wr(logic [4:0] a);
    ce && avs_write && !st_q.waitreq && avs_byteenable[0] && avs_address == a;
  endsequence
  sequence s_fall_slot;
    ce && fall && !drv_aud;
  endsequence

  a_bus_answer: assert property (ce && req && st_q.waitreq |=> !avs_waitrequest)
    else $error("waitrequest not released after one cycle");
  a_gain_tx_on: assert property (s_fall_slot and drv_gain |=> !tdm_dout_oe_n)
    else $error("gain slot not driven");
  a_gain_slot_wr: assert property (s_wr(REG_GAIN_SLOT) |=> st_q.gain_cfg[5:0] == $past(avs_writedata[5:0]))
    else $error("gain slot not stored");
  a_pin_off: assert property ((ce && pin_fn == TSGA_PF_OFF)[*2] |-> chip_link_pin_oe_n)
    else $error("link pin driven while buffers off");
  a_pin_gpo: assert property ((ce && pin_fn == TSGA_PF_GPO)[*2] |-> !chip_link_pin_oe_n &&
    chip_link_pin_o == $past(st_q.gpo)) else $error("general purpose output not driven");
  a_pin_gpi: assert property ((ce && pin_fn == TSGA_PF_GPI)[*2] |=> st_q.gpi == $past(st_q.link_s[1]))
    else $error("general purpose input not sampled");
  a_audio_short: assert property (ce && fall && drv_aud && !st_q.audio_cfg[SLEN_BIT] &&
    bitpos >= SLOT_BITS_W'(AUDIO_SHORT) |=> !tdm_dout) else $error("16 bit audio word overran");
  a_audio_off: assert property (ce && fall && !audio_en && !drv_gain |=> tdm_dout_oe_n)
    else $error("audio driven while disabled");
  a_audio_slot_wr: assert property (s_wr(REG_AUDIO) |=> st_q.audio_cfg[5:0] == $past(avs_writedata[5:0]))
    else $error("audio slot not stored");
  a_bo_align_off: assert property ((ce && !st_q.align_cfg[BO_EN_BIT])[*2] |->
    brownout_gain_aligned == $past(brownout_gain)) else $error("brownout gain aligned while disabled");
  a_start_slot_wr: assert property (s_wr(REG_ALIGN) |=> start == $past(avs_writedata[6:1]))
    else $error("group start slot not stored");
  a_lim_align_off: assert property ((ce && !st_q.align_cfg[LIM_EN_BIT])[*2] |->
    limiter_gain_aligned == $past(gain_reduction)) else $error("limiter gain aligned while disabled");
  a_member_step: assert property (ce && rise && !fstart && align_mode && st_q.member_sel[1] &&
    slot == SLOT_W'(start + SLOT_W'(MEMBER_STEP)) && bitpos < SLOT_BITS_W'(GAIN_W)
    |=> st_q.peer_sh[0] == $past(st_q.link_s[1]))
    else $error("member slot not captured");
  a_member_start: assert property (ce && rise && !fstart && align_mode && st_q.member_sel[0] &&
    slot == start && bitpos < SLOT_BITS_W'(GAIN_W) |=> st_q.peer_sh[0] == $past(st_q.link_s[1]))
    else $error("start slot not captured");
  a_reserved_zero: assert property (s_wr(REG_PIN_CFG) |=> (st_q.pin_cfg & ~MASK_PIN) == 8'h00)
    else $error("reserved bits stored");
endmodule

`default_nettype wire

// File: tb/tsga_peer.sv
// Host and peer model: frames the TDM link, samples the device's slots, drives peer gain words on the chip link
`timescale 1ns/1ps
`default_nettype none
module tsga_peer (
  // TDM pins
  output logic      tdm_bclk,
  output logic      tdm_fsync,
  input  wire logic tdm_dout,
  input  wire logic tdm_dout_oe_n,
  // Chip link level put out by the peers
  output logic      peer_link
);
  logic       cap_d     [0:511];
  logic       cap_oe    [0:511];
  logic [7:0] peer_word [0:63];
  logic       peer_en   [0:63];
  initial begin
    tdm_bclk = 1'b0;
    tdm_fsync = 1'b0;
    peer_link = 1'b0;
    for (int s = 0; s < 64; s++) begin
      peer_en[s] = 1'b0;
    end
  end
  task automatic set_link(input logic v);
    peer_link = v;
  endtask
  // Bit clock stands still outside frames; bit k goes out on the fall after rise k
  task automatic run_frame(input int nbits);
    int s;
    int b;
    #37;
    for (int i = 0; i <= nbits; i++) begin
      tdm_fsync = (i == 0);
      #400;
      tdm_bclk = 1'b1;
      if (i > 0) begin
        cap_d[i-1] = tdm_dout;
        cap_oe[i-1] = tdm_dout_oe_n;
      end
      #400;
      tdm_bclk = 1'b0;
      s = (i / 32) % 64;
      b = i % 32;
      // Released line toggles so a stale value never reads as data
      if (peer_en[s] && b < 8) begin
        peer_link = peer_word[s][7-b];
      end else begin
        peer_link = ~peer_link;
      end
    end
    tdm_fsync = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the TDM slot and gain alignment block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tsga_pkg::*;
  logic        core_clk, rst, ce, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        tdm_bclk, tdm_fsync, tdm_dout, tdm_dout_oe_n;
  logic        link_o, link_oe_n, peer_link, aud_valid, aud_ready;
  wire logic   link_i;
  logic [23:0] aud_data;
  logic [7:0]  gain_reduction, brownout_gain, lim_al, bo_al;
  int          num_errors, checks_done;
  localparam logic [4:0] RA [0:5] = '{REG_GAIN_SLOT, REG_PIN_CFG, REG_AUDIO, REG_ALIGN, REG_MEMBER, REG_LINK_GPIO};
  localparam logic [7:0] RV [0:5] = '{RST_GAIN_SLOT, RST_PIN_CFG, RST_AUDIO, RST_ALIGN, RST_MEMBER, 8'h00};
  localparam logic [7:0] RM [0:5] = '{MASK_GAIN, MASK_PIN, MASK_FULL, MASK_FULL, MASK_FULL, MASK_GPIO};
  assign link_i = link_oe_n ? peer_link : link_o;
  tsga_top dut (.core_clk(core_clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tdm_bclk(tdm_bclk), .tdm_fsync(tdm_fsync),
    .tdm_dout(tdm_dout), .tdm_dout_oe_n(tdm_dout_oe_n), .chip_link_pin_i(link_i), .chip_link_pin_o(link_o),
    .chip_link_pin_oe_n(link_oe_n), .aud_data(aud_data), .aud_valid(aud_valid), .aud_ready(aud_ready),
    .gain_reduction(gain_reduction), .brownout_gain(brownout_gain), .limiter_gain_aligned(lim_al),
    .brownout_gain_aligned(bo_al));
  tsga_peer peer (.tdm_bclk(tdm_bclk), .tdm_fsync(tdm_fsync), .tdm_dout(tdm_dout),
    .tdm_dout_oe_n(tdm_dout_oe_n), .peer_link(peer_link));
  always #50 core_clk = ~core_clk;
  task automatic end_sim;
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Request held until the edge that samples waitrequest low
  task automatic av(input logic [4:0] a, input logic w, input logic [7:0] d, input logic [3:0] be,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'ha5a5a5, d};
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      num_errors++;
      end_sim();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    av(a, 1'b1, d, 4'hf, q);
  endtask
  task automatic push(input logic [23:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    aud_data <= d;
    aud_valid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (aud_ready !== 1'b1 && n < 100);
    if (n >= 100) begin
      num_errors++;
      end_sim();
    end
    aud_valid <= 1'b0;
  endtask
  task automatic slot(input int s, output logic [31:0] w, output logic [31:0] oe);
    for (int b = 0; b < 32; b++) begin
      w[31-b] = peer.cap_d[s*32+b];
      oe[31-b] = peer.cap_oe[s*32+b];
    end
  endtask
  task automatic t_regs;
    logic [31:0] q;
    for (int i = 0; i < 6; i++) begin
      av(RA[i], 1'b0, 8'h00, 4'h1, q);
      chk(q, {24'h0, RV[i]});
      wr(RA[i], 8'hff);
      av(RA[i], 1'b0, 8'h00, 4'h1, q);
      chk(q, {24'h0, RM[i]});
    end
    av(REG_GAIN_SLOT, 1'b1, 8'h55, 4'h0, q);
    av(REG_GAIN_SLOT, 1'b0, 8'h00, 4'h1, q);
    chk(q, 32'h7f);
    wr(5'h00, 8'h5a);
    av(5'h00, 1'b0, 8'h00, 4'h1, q);
    chk(q, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(RA[i], RV[i]);
    end
  endtask
  task automatic t_tx;
    logic [31:0] w, oe;
    gain_reduction <= 8'h9b;
    wr(REG_GAIN_SLOT, 8'h40);
    wr(REG_AUDIO, 8'hc1);
    push(24'ha5c3e1);
    peer.run_frame(64);
    slot(0, w, oe);
    chk(w, 32'h9b000000);
    chk(oe, 32'h0);
    slot(1, w, oe);
    chk(w, 32'ha5c3e100);
    chk(oe, 32'h0);
    wr(REG_GAIN_SLOT, 8'h00);
    wr(REG_AUDIO, 8'h41);
    push(24'h3c5a96);
    peer.run_frame(64);
    slot(0, w, oe);
    chk(oe, 32'hffffffff);
    slot(1, w, oe);
    chk(w, 32'h3c5a0000);
    // This word stays queued while audio is off
    wr(REG_AUDIO, 8'h01);
    push(24'h123456);
    peer.run_frame(64);
    slot(1, w, oe);
    chk(oe, 32'hffffffff);
  endtask
  task automatic t_align;
    peer.peer_word[2] = 8'h60;
    peer.peer_word[5] = 8'h50;
    peer.peer_word[8] = 8'h7f;
    peer.peer_en[2] = 1'b1;
    peer.peer_en[5] = 1'b1;
    peer.peer_en[8] = 1'b1;
    wr(REG_ALIGN, 8'h85);
    gain_reduction <= 8'h10;
    brownout_gain <= 8'h20;
    for (int c = 0; c < 2; c++) begin
      wr(REG_MEMBER, (c == 0) ? 8'h03 : 8'h02);
      peer.run_frame(288);
      peer.run_frame(2);
      @(negedge core_clk);
      chk(lim_al, (c == 0) ? 8'h60 : 8'h50);
      chk(bo_al, (c == 0) ? 8'h60 : 8'h50);
    end
    // Limiter alignment alone must leave the brownout gain untouched
    wr(REG_ALIGN, 8'h05);
    repeat (3) @(negedge core_clk);
    chk(lim_al, 8'h50);
    chk(bo_al, 8'h20);
    wr(REG_ALIGN, 8'h04);
    repeat (3) @(negedge core_clk);
    chk(lim_al, 8'h10);
    chk(bo_al, 8'h20);
  endtask
  task automatic t_pin;
    logic [31:0] q;
    logic [7:0]  off [0:4] = '{8'h08, 8'h04, 8'h14, 8'h18, 8'h1c};
    wr(REG_PIN_CFG, 8'h10);
    wr(REG_LINK_GPIO, 8'h01);
    repeat (3) @(negedge core_clk);
    chk(link_o, 1'b1);
    chk(link_oe_n, 1'b0);
    peer.set_link(1'b1);
    wr(REG_PIN_CFG, 8'h0c);
    repeat (4) @(negedge core_clk);
    chk(link_oe_n, 1'b1);
    av(REG_LINK_GPIO, 1'b0, 8'h00, 4'h1, q);
    chk(q, 32'h03);
    peer.set_link(1'b0);
    repeat (4) @(negedge core_clk);
    av(REG_LINK_GPIO, 1'b0, 8'h00, 4'h1, q);
    chk(q, 32'h01);
    for (int i = 0; i < 5; i++) begin
      wr(REG_PIN_CFG, 8'h10);
      wr(REG_PIN_CFG, off[i]);
      repeat (3) @(negedge core_clk);
      chk(link_oe_n, 1'b1);
    end
    wr(REG_PIN_CFG, 8'h00);
  endtask
  task automatic t_fifo;
    logic [31:0] w, oe;
    int          n;
    logic        acc;
    n = 0;
    wr(REG_AUDIO, 8'hc0);
    aud_data <= 24'h010000;
    aud_valid <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      acc = (aud_ready === 1'b1);
      if (acc) begin
        n++;
        aud_data <= aud_data + 24'h000001;
      end
    end
    aud_valid <= 1'b0;
    chk(n, 32'd15);
    for (int k = 0; k < 16; k++) begin
      peer.run_frame(32);
      slot(0, w, oe);
      chk(w, (k == 0) ? 32'h12345600 : {24'h010000 + 24'(k - 1), 8'h00});
    end
    chk(aud_ready, 1'b1);
    peer.run_frame(32);
    slot(0, w, oe);
    chk(oe, 32'hffffffff);
  endtask
  // Clock enable freezes the aligned gain; a mid-run reset restores the registers
  task automatic t_ce;
    logic [31:0] q;
    @(posedge core_clk);
    ce <= 1'b0;
    gain_reduction <= 8'h44;
    repeat (4) @(posedge core_clk);
    chk(lim_al, 8'h10);
    ce <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(lim_al, 8'h44);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    av(REG_GAIN_SLOT, 1'b0, 8'h00, 4'h1, q);
    chk(q, {24'h0, RST_GAIN_SLOT});
    chk(tdm_dout_oe_n, 1'b1);
  endtask
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    {avs_read, avs_write, aud_valid} = 3'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    aud_data = 24'h0;
    gain_reduction = 8'h00;
    brownout_gain = 8'h00;
    num_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_tx();
    t_align();
    t_pin();
    t_fifo();
    t_ce();
    end_sim();
  end
  initial begin
    #5000000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
